// ===== logic/sgx_gpio.sv
// Summary of operation
// [R01] six pins on register bits 7 to 2, bits 1 and 0 reserved
// [R02] writing ones to the set register drives those pins high
// [R03] writing ones to the clear register drives those pins low
// [R04] monitor register reads live pin levels, writes ignored
// [R05] direction bit zero means input, one output; resets to zero
// [R06] edge status bit sets on any enabled edge
// [R07] rising enable records low-to-high transitions
// [R08] falling enable records high-to-low transitions
// [R09] function bit zero gives pin to touch/adc, one to gpio; reset 0x0f
// [R10] all pins are inputs after power-up reset
// [R11] block held in reset while power-on reset asserted
// [R12] software should make unused pins outputs to save power
// [R13] set and clear registers are eight bits, reset to zero
// [R14] inputs synchronised, edge is change from previous sample
// [R15] writing one clears an edge bit; a same-cycle edge keeps it set
`timescale 1ns/1ps
module sgx_gpio (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [sgx_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sgx_pkg::DATA_W-1:0] reg_wdata,
  output logic      [sgx_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_rvalid,
  input  wire logic [sgx_pkg::PIN_N-1:0]  pin_in,
  output logic      [sgx_pkg::PIN_N-1:0]  pin_out,
  output logic      [sgx_pkg::PIN_N-1:0]  pin_oe_n,
  output logic      [sgx_pkg::PIN_N-1:0]  pin_gpio_sel
);
  import sgx_pkg::*;

  // ========================================
  // registers
  logic [DATA_W-1:0] out_q, out_d;
  logic [DATA_W-1:0] dir_q, dir_d;
  logic [DATA_W-1:0] edge_q, edge_d;
  logic [DATA_W-1:0] rise_en_q, rise_en_d;
  logic [DATA_W-1:0] fall_en_q, fall_en_d;
  logic [DATA_W-1:0] func_q, func_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;
  logic [PIN_N-1:0]  oe_n_q, oe_n_d;
  logic [PIN_N-1:0]  pout_q, pout_d;
  logic [PIN_N-1:0]  gsel_q, gsel_d;
  logic [PIN_N-1:0]  lvl;
  logic [PIN_N-1:0]  rise;
  logic [PIN_N-1:0]  fall;
  logic [DATA_W-1:0] lvl_w;
  logic [DATA_W-1:0] hit_w;
  logic              wr_set;
  logic              wr_clr;
  logic              wr_dir;
  logic              wr_edge;
  logic              wr_rise;
  logic              wr_fall;
  logic              wr_func;
  sgx_acc_type       acc_q, acc_d;

  // ========================================
  // input path
  // [R14] synchroniser stage
  sgx_sync #(.WIDTH(PIN_N)) u_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .async_in  (pin_in),
    .level_out (lvl)
  );
  sgx_edge #(.WIDTH(PIN_N)) u_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  // ========================================
  // elaboration checks
  // the map below is built for one byte with the pins on its upper bits
  if (PIN_HI - PIN_LO + 1 != PIN_N) begin : g_chk_map
    $error("pin map and pin count disagree");
  end
  if (PIN_HI >= DATA_W) begin : g_chk_top
    $error("top pin lies outside the register");
  end
  if (PIN_LO == 0) begin : g_chk_low
    $error("no reserved bits below the pins");
  end
  if (ADDR_W < 8) begin : g_chk_addr
    $error("address bus narrower than the offsets");
  end
  if (SYNC_N != 3) begin : g_chk_sync
    $error("synchroniser depth other than three");
  end
  if (DATA_W != 8) begin : g_chk_data
    $error("registers are one byte wide");
  end

  // ========================================
  // write decode
  always_comb begin
    wr_set  = 1'b0;
    wr_clr  = 1'b0;
    wr_dir  = 1'b0;
    wr_edge = 1'b0;
    wr_rise = 1'b0;
    wr_fall = 1'b0;
    wr_func = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFF_SET:  wr_set  = 1'b1;
        OFF_CLR:  wr_clr  = 1'b1;
        OFF_DIR:  wr_dir  = 1'b1;
        OFF_EDGE: wr_edge = 1'b1;
        OFF_RISE: wr_rise = 1'b1;
        OFF_FALL: wr_fall = 1'b1;
        OFF_FUNC: wr_func = 1'b1;
        // [R04] monitor and unmapped writes dropped
        default:  wr_set  = 1'b0;
      endcase
    end
  end

  // ========================================
  // per-pin wiring
  for (genvar k = 0; k < PIN_N; k++) begin : g_pin
    // [R07] [R08] only enabled edges
    assign hit_w[PIN_LO+k] = (rise[k] & rise_en_q[PIN_LO+k]) |
                             (fall[k] & fall_en_q[PIN_LO+k]);
    // [R04] live pin level
    assign lvl_w[PIN_LO+k] = lvl[k];
    // touch/adc pins are never driven, whatever the direction bit says
    assign oe_n_d[k] = ~(dir_d[PIN_LO+k] & func_d[PIN_LO+k]);
    assign pout_d[k] = out_d[PIN_LO+k];
    // [R09] select follows function
    assign gsel_d[k] = func_d[PIN_LO+k];
  end
  // [R01] reserved bits empty
  assign hit_w[PIN_LO-1:0] = '0;
  assign lvl_w[PIN_LO-1:0] = '0;

  // ========================================
  // output latch
  always_comb begin
    out_d = out_q;
    // [R02] ones drive high
    if (wr_set) begin
      out_d = out_q | (reg_wdata & PIN_MASK);
    end
    // [R03] ones drive low
    if (wr_clr) begin
      out_d = out_q & ~(reg_wdata & PIN_MASK);
    end
  end
  always_ff @(posedge core_clk) begin
    // [R13] latch resets to zero
    if (rst) begin
      out_q <= RST_ZERO;
    end else begin
      out_q <= out_d;
    end
  end

  // ========================================
  // configuration
  always_comb begin
    dir_d     = dir_q;
    rise_en_d = rise_en_q;
    fall_en_d = fall_en_q;
    func_d    = func_q;
    // [R05] one makes output
    if (wr_dir) begin
      dir_d = reg_wdata & PIN_MASK;
    end
    // [R07] rising enables
    if (wr_rise) begin
      rise_en_d = reg_wdata & PIN_MASK;
    end
    // [R08] falling enables
    if (wr_fall) begin
      fall_en_d = reg_wdata & PIN_MASK;
    end
    // [R09] all eight bits kept
    if (wr_func) begin
      func_d = reg_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    // [R05] [R10] inputs after reset
    if (rst) begin
      dir_q     <= RST_ZERO;
      rise_en_q <= RST_ZERO;
      fall_en_q <= RST_ZERO;
      func_q    <= RST_FUNC;
    end else begin
      dir_q     <= dir_d;
      rise_en_q <= rise_en_d;
      fall_en_q <= fall_en_d;
      func_q    <= func_d;
    end
  end

  // ========================================
  // edge status
  always_comb begin
    edge_d = edge_q;
    // [R15] write one clears
    if (wr_edge) begin
      edge_d = edge_q & ~reg_wdata;
    end
    // [R06] applied last, so a same-cycle clear loses
    edge_d = edge_d | hit_w;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      edge_q <= RST_ZERO;
    end else begin
      edge_q <= edge_d;
    end
  end

  // ========================================
  // read handshake
  always_comb begin
    acc_d = acc_q;
    case (acc_q)
      SGX_ACC_IDLE: begin
        if (reg_rd) begin
          acc_d = SGX_ACC_DONE;
        end
      end
      // back-to-back reads stay here and answer every cycle
      SGX_ACC_DONE: begin
        if (!reg_rd) begin
          acc_d = SGX_ACC_IDLE;
        end
      end
      default: acc_d = SGX_ACC_IDLE;
    endcase
    rvalid_d = (acc_d == SGX_ACC_DONE);
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q    <= SGX_ACC_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ========================================
  // read data
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        // set and clear both read back the output latch
        OFF_SET:  rdata_d = out_q;
        OFF_CLR:  rdata_d = out_q;
        // [R04] live levels
        OFF_MON:  rdata_d = lvl_w;
        OFF_DIR:  rdata_d = dir_q;
        OFF_EDGE: rdata_d = edge_q;
        OFF_RISE: rdata_d = rise_en_q;
        OFF_FALL: rdata_d = fall_en_q;
        OFF_FUNC: rdata_d = func_q;
        default:  rdata_d = RST_ZERO;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= RST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ========================================
  // pin drive
  always_ff @(posedge core_clk) begin
    // [R11] [R10] released while reset held
    // released pins cannot fight whatever the far side drives
    if (rst) begin
      oe_n_q <= '1;
      pout_q <= '0;
      gsel_q <= RST_FUNC[PIN_HI:PIN_LO];
    end else begin
      oe_n_q <= oe_n_d;
      pout_q <= pout_d;
      gsel_q <= gsel_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rvalid   = rvalid_q;
  assign pin_out      = pout_q;
  assign pin_oe_n     = oe_n_q;
  assign pin_gpio_sel = gsel_q;
endmodule

// ===== logic/sgx_pkg.sv
package sgx_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PIN_LO   = 2;
  localparam int unsigned PIN_HI   = 7;
  localparam int unsigned PIN_N    = 6;
  localparam int unsigned SYNC_N   = 3;
  localparam logic [7:0] OFF_SET   = 8'h10;
  localparam logic [7:0] OFF_CLR   = 8'h11;
  localparam logic [7:0] OFF_MON   = 8'h12;
  localparam logic [7:0] OFF_DIR   = 8'h13;
  localparam logic [7:0] OFF_EDGE  = 8'h14;
  localparam logic [7:0] OFF_RISE  = 8'h15;
  localparam logic [7:0] OFF_FALL  = 8'h16;
  localparam logic [7:0] OFF_FUNC  = 8'h17;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_FUNC  = 8'h0f;
  localparam logic [7:0] PIN_MASK  = 8'hfc;
  typedef enum logic [1:0] {
    SGX_ACC_IDLE,
    SGX_ACC_DONE
  } sgx_acc_type;
endpackage

// ===== logic/sgx_sync.sv
`timescale 1ns/1ps
module sgx_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  import sgx_pkg::*;
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, lvl_d;
  // ========================================
  // three stages, change taken when two and three agree
  if (WIDTH < 1) begin : g_chk_width
    $error("synchroniser needs at least one bit");
  end
  always_comb begin
    s1_d = async_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end
  assign level_out = lvl_q;
endmodule

// ===== logic/sgx_edge.sv
`timescale 1ns/1ps
module sgx_edge #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  import sgx_pkg::*;
  logic [WIDTH-1:0] prev_q, prev_d;
  if (WIDTH < 1) begin : g_chk_width
    $error("edge detector needs at least one bit");
  end
  always_comb begin
    prev_d = level;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end
  // [R14] compare with previous
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule

// ===== bench/sgx_pin_model.sv
`timescale 1ns/1ps
module sgx_pin_model (
  input  logic [5:0] pin_out,
  input  logic [5:0] pin_oe_n,
  input  logic [5:0] ext_lvl,
  output logic [5:0] pin_lvl
);
  // a driven pin reads back its own level, an input the far side
  assign pin_lvl = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

// ===== bench/sgx_gpio_assertions.sv
`timescale 1ns/1ps
module sgx_gpio_assertions (
  input logic       core_clk,
  input logic       rst,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_rvalid,
  input logic [5:0] pin_out,
  input logic [5:0] pin_oe_n,
  input logic [5:0] pin_gpio_sel
);
  import sgx_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_rd_pulse: assert property (reg_rd |=> reg_rvalid)
    else $error("no read valid");
  a_rd_idle: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read valid");
  a_set_pins: assert property (s_wr(OFF_SET) |=>
    &(pin_out | ~$past(reg_wdata[7:2]))) else $error("set failed");
  a_clr_pins: assert property (s_wr(OFF_CLR) |=>
    !(|(pin_out & $past(reg_wdata[7:2])))) else $error("clear failed");
  a_out_hold: assert property (!reg_wr |=> $stable(pin_out))
    else $error("output moved");
  a_dir_in: assert property (reg_wr && reg_addr == OFF_DIR &&
    reg_wdata == 8'h00 |=> pin_oe_n == 6'h3f) else $error("not input");
  a_func_sel: assert property (s_wr(OFF_FUNC) |=>
    pin_gpio_sel == $past(reg_wdata[7:2])) else $error("bad select");
  a_por_state: assert property ($fell(rst) |-> pin_oe_n == 6'h3f &&
    pin_gpio_sel == 6'h03) else $error("bad reset state");
endmodule
bind sgx_gpio sgx_gpio_assertions chk_u (
  .core_clk     (core_clk),
  .rst          (rst),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_rvalid   (reg_rvalid),
  .pin_out      (pin_out),
  .pin_oe_n     (pin_oe_n),
  .pin_gpio_sel (pin_gpio_sel)
);

// ===== bench/sgx_gpio_test.sv
`timescale 1ns/1ps
module sgx_gpio_test;
  import sgx_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [5:0] pin_in, pin_out, pin_oe_n, pin_gpio_sel;
  logic [5:0] ext_lvl = 6'h00;
  int         fails = 0;
  int         num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  sgx_gpio dut_u (
    .core_clk     (core_clk),
    .rst          (rst),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .reg_rvalid   (reg_rvalid),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe_n     (pin_oe_n),
    .pin_gpio_sel (pin_gpio_sel)
  );
  sgx_pin_model pin_u (
    .pin_out  (pin_out),
    .pin_oe_n (pin_oe_n),
    .ext_lvl  (ext_lvl),
    .pin_lvl  (pin_in)
  );
  // ======
  // bus tasks
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp("rdata", exp, reg_rdata);
  endtask
  // ======
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rd(OFF_SET + 8'(i), 8'h00);
    end
    rd(OFF_FUNC, RST_FUNC);
    rd(8'h20, 8'h00);
    cmp("oe_n", 8'h3f, {2'h0, pin_oe_n});
    cmp("gsel", 8'h03, {2'h0, pin_gpio_sel});
  endtask
  task automatic t_drive;
    wr(OFF_FUNC, 8'hfc);
    cmp("gsel", 8'h3f, {2'h0, pin_gpio_sel});
    wr(OFF_DIR, 8'hfc);
    wr(OFF_SET, 8'ha7);
    cmp("set", 8'h29, {2'h0, pin_out});
    wr(OFF_CLR, 8'h24);
    wr(OFF_SET, 8'h00);
    cmp("clr", 8'h20, {2'h0, pin_out});
    cmp("oe_n", 8'h00, {2'h0, pin_oe_n});
    repeat (6) @(posedge core_clk);
    wr(OFF_MON, 8'hff);
    rd(OFF_MON, 8'h80);
    wr(OFF_DIR, 8'h00);
    cmp("oe_n", 8'h3f, {2'h0, pin_oe_n});
  endtask
  task automatic t_edge;
    // let the release of the driven pin settle before arming
    repeat (8) @(posedge core_clk);
    wr(OFF_RISE, 8'h04);
    wr(OFF_FALL, 8'h08);
    @(posedge core_clk) ext_lvl <= 6'h03;
    repeat (8) @(posedge core_clk);
    rd(OFF_EDGE, 8'h04);
    @(posedge core_clk) ext_lvl <= 6'h00;
    repeat (8) @(posedge core_clk);
    rd(OFF_EDGE, 8'h0c);
    wr(OFF_EDGE, 8'h04);
    rd(OFF_EDGE, 8'h08);
    // pin edge lands five edges on; the clearing write is taken on it
    @(posedge core_clk) ext_lvl <= 6'h01;
    repeat (3) @(posedge core_clk);
    wr(OFF_EDGE, 8'h04);
    rd(OFF_EDGE, 8'h0c);
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_EDGE, 8'h00);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_drive;
    t_edge;
    end_sim;
  end
  // whole run is under a hundred cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    end_sim;
  end
endmodule
